// File: sllcr_pkg.sv
// package: register map, field layout and reset values of the serial link lane config bank
package sllcr_pkg;
    // -----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // -----------------------------------------------------------------
    localparam logic [7:0] IDX_LANE_DEEMPH_SHARED = 8'h12;
    localparam logic [7:0] IDX_LANE0_DEEMPH = 8'h13;
    localparam logic [7:0] IDX_LANE2_DEEMPH = 8'h14;
    localparam logic [7:0] IDX_LANE3_DEEMPH = 8'h15;
    localparam logic [7:0] IDX_SERIALIZER_PLL_MODE = 8'h16;
    localparam logic [7:0] IDX_PLL_RESET_LANE_PDN = 8'h17;
    localparam logic [7:0] IDX_CHAN_A_LANE_MAPPING = 8'h31;
    localparam logic [7:0] IDX_CHAN_B_LANE_MAPPING = 8'h32;
    localparam int NUM_REGS = 8;
    localparam int ADDR_W = 10;
    // -----------------------------------------------------------------
    // field layout
    // -----------------------------------------------------------------
    localparam int DEEMPH_LSB = 2;
    localparam int DEEMPH_W = 6;
    localparam logic [7:0] DEEMPH_MASK = 8'hfc;
    localparam logic [7:0] SHARED_MASK = 8'hfe;
    localparam logic [7:0] PLL_MODE_MASK = 8'h03;
    localparam logic [7:0] PDN_REG_MASK = 8'h68;
    localparam logic [7:0] MAP_MASK = 8'hff;
    localparam int PLL_RESET_BIT = 6;
    localparam int OFF_HI_BIT = 5;
    localparam int OFF_LO_BIT = 3;
    localparam logic [1:0] PLL_MODE_20X = 2'h0;
    localparam logic [1:0] PLL_MODE_40X = 2'h2;
    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] RST_DEEMPH = 8'h00;
    localparam logic [7:0] RST_PLL_MODE = 8'h00;
    localparam logic [7:0] RST_PDN = 8'h00;
    localparam logic [7:0] RST_MAP = 8'h00;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage : sllcr_pkg

// File: sllcr_mem_if.sv
// interface: write and read ports of the register storage
`timescale 1ns/1ps
`default_nettype none
interface sllcr_mem_if;
    logic we;
    logic [2:0] waddr;
    logic [7:0] wdata;
    logic [2:0] raddr;
    logic [7:0] rdata;
    logic [7:0] regs [8];
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata, input regs);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata, output regs);
endinterface : sllcr_mem_if
`default_nettype wire

// File: sllcr_regfile.sv
// storage of the eight 8-bit configuration registers with registered read port
`timescale 1ns/1ps
`default_nettype none
module sllcr_regfile
    import sllcr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    sllcr_mem_if.mem m
);
    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] rdata_q;
    // -----------------------------------------------------------------
    // writable mask per slot
    // -----------------------------------------------------------------
    function automatic logic [7:0] slot_mask(input logic [2:0] s);
        unique case (s)
            3'h0: slot_mask = SHARED_MASK;
            3'h1, 3'h2, 3'h3: slot_mask = DEEMPH_MASK;
            3'h4: slot_mask = PLL_MODE_MASK;
            3'h5: slot_mask = PDN_REG_MASK;
            3'h6, 3'h7: slot_mask = MAP_MASK;
        endcase
    endfunction : slot_mask
    function automatic logic [7:0] slot_reset(input logic [2:0] s);
        unique case (s)
            3'h0, 3'h1, 3'h2, 3'h3: slot_reset = RST_DEEMPH;
            3'h4: slot_reset = RST_PLL_MODE;
            3'h5: slot_reset = RST_PDN;
            3'h6, 3'h7: slot_reset = RST_MAP;
        endcase
    endfunction : slot_reset
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_REGS; i++) begin
            if (rst) begin
                regs_q[i] <= slot_reset(3'(i));
            end else if (m.we && m.waddr == 3'(i)) begin
                regs_q[i] <= m.wdata & slot_mask(3'(i));
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= regs_q[m.raddr];
        end
    end
    assign m.rdata = rdata_q;
    assign m.regs = regs_q;
endmodule : sllcr_regfile
`default_nettype wire

// File: sllcr_top.sv
// top: wishbone slave and decoded outputs of the serial link lane config bank
`timescale 1ns/1ps
`default_nettype none
module sllcr_top
    import sllcr_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [sllcr_pkg::ADDR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [7:0] CHAN_A_LANE_MAP,
    output logic [7:0] CHAN_B_LANE_MAP,
    output logic [5:0] LANE0_DEEMPHASIS,
    output logic [5:0] LANE1_DEEMPHASIS,
    output logic [5:0] LANE2_DEEMPHASIS,
    output logic [5:0] LANE3_DEEMPHASIS,
    output logic [1:0] SERIALIZER_PLL_FACTOR,
    output logic LANES_PER_CONV_FOUR,
    output logic PLL_FACTOR_VALID,
    output logic SERIALIZER_PLL_RESET,
    output logic OUTER_LANES_OFF
);
    typedef enum logic [1:0] {SLLCR_IDLE, SLLCR_READ, SLLCR_ACK} sllcr_state_t;
    sllcr_state_t state_q, state_d;
    sllcr_mem_if mi ();
    logic ack_q;
    logic ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic [7:0] map_a_q;
    logic [7:0] map_a_d;
    logic [7:0] map_b_q;
    logic [7:0] map_b_d;
    logic [5:0] emp_q [4];
    logic [5:0] emp_d [4];
    logic [1:0] factor_q;
    logic [1:0] factor_d;
    logic four_q;
    logic four_d;
    logic valid_q;
    logic valid_d;
    logic prst_q;
    logic prst_d;
    logic off_q;
    logic off_d;
    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    function automatic logic [3:0] decode(input logic [7:0] idx);
        unique case (idx)
            IDX_LANE_DEEMPH_SHARED: decode = 4'h8;
            IDX_LANE0_DEEMPH: decode = 4'h9;
            IDX_LANE2_DEEMPH: decode = 4'ha;
            IDX_LANE3_DEEMPH: decode = 4'hb;
            IDX_SERIALIZER_PLL_MODE: decode = 4'hc;
            IDX_PLL_RESET_LANE_PDN: decode = 4'hd;
            IDX_CHAN_A_LANE_MAPPING: decode = 4'he;
            IDX_CHAN_B_LANE_MAPPING: decode = 4'hf;
            default: decode = 4'h0;
        endcase
    endfunction : decode
    wire logic req = WB_CYC_I && WB_STB_I && !ack_q;
    wire logic word_ok = (WB_ADR_I[1:0] == 2'b00);
    wire logic [3:0] dec = decode(WB_ADR_I[9:2]);
    wire logic hit = word_ok && dec[3];
    wire logic [2:0] slot = dec[2:0];
    wire logic lane0_sel = WB_SEL_I[0];
    // -----------------------------------------------------------------
    // bus sequencing: writes and unmapped reads ack next cycle, mapped reads after storage read
    // -----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SLLCR_IDLE: if (req) state_d = (WB_WE_I || !hit) ? SLLCR_ACK : SLLCR_READ;
            SLLCR_READ: state_d = SLLCR_ACK;
            SLLCR_ACK: state_d = SLLCR_IDLE;
        endcase
    end
    assign mi.we = (state_q == SLLCR_IDLE) && req && WB_WE_I && hit && lane0_sel;
    assign mi.waddr = slot;
    assign mi.wdata = WB_DAT_I[7:0];
    assign mi.raddr = slot;
    // -----------------------------------------------------------------
    // register storage
    // -----------------------------------------------------------------
    sllcr_regfile u_regfile (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .m(mi)
    );
    // -----------------------------------------------------------------
    // bus registers
    // -----------------------------------------------------------------
    wire logic take = (state_q == SLLCR_IDLE) && req;
    wire logic rd_done = (state_q == SLLCR_READ);
    assign ack_d = (state_d == SLLCR_ACK);
    assign dat_d = rd_done ? {24'h000000, mi.rdata} : (take ? UNMAPPED_READ : dat_q);
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state_q <= SLLCR_IDLE;
        end else begin
            state_q <= state_d;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            dat_q <= UNMAPPED_READ;
        end else begin
            dat_q <= dat_d;
        end
    end
    // -----------------------------------------------------------------
    // field decode to transmitter controls
    // -----------------------------------------------------------------
    wire logic [7:0] r_shared = mi.regs[0];
    wire logic [7:0] r_lane0 = mi.regs[1];
    wire logic [7:0] r_lane2 = mi.regs[2];
    wire logic [7:0] r_lane3 = mi.regs[3];
    wire logic [7:0] r_pll = mi.regs[4];
    wire logic [7:0] r_pdn = mi.regs[5];
    wire logic [7:0] r_map_a = mi.regs[6];
    wire logic [7:0] r_map_b = mi.regs[7];
    wire logic [1:0] pll_f = r_pll[1:0];
    // -----------------------------------------------------------------
    // de-emphasis field of a lane register
    // -----------------------------------------------------------------
    function automatic logic [5:0] deemph_field(input logic [7:0] r);
        deemph_field = r[DEEMPH_LSB +: DEEMPH_W];
    endfunction : deemph_field
    // -----------------------------------------------------------------
    // next values of the transmitter controls
    // -----------------------------------------------------------------
    assign emp_d[0] = deemph_field(r_lane0);
    assign emp_d[1] = deemph_field(r_shared);
    assign emp_d[2] = deemph_field(r_lane2);
    assign emp_d[3] = deemph_field(r_lane3);
    assign map_a_d = r_map_a;
    assign map_b_d = r_map_b;
    assign factor_d = pll_f;
    assign four_d = (pll_f == PLL_MODE_20X);
    assign valid_d = (pll_f == PLL_MODE_20X) || (pll_f == PLL_MODE_40X);
    assign prst_d = r_pdn[PLL_RESET_BIT];
    assign off_d = r_pdn[OFF_HI_BIT] && r_pdn[OFF_LO_BIT];
    // -----------------------------------------------------------------
    // transmitter control registers
    // -----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            for (int i = 0; i < 4; i++) begin
                emp_q[i] <= RST_DEEMPH[DEEMPH_LSB +: DEEMPH_W];
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                emp_q[i] <= emp_d[i];
            end
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            map_a_q <= RST_MAP;
            map_b_q <= RST_MAP;
        end else begin
            map_a_q <= map_a_d;
            map_b_q <= map_b_d;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            factor_q <= RST_PLL_MODE[1:0];
            four_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            factor_q <= factor_d;
            four_q <= four_d;
            valid_q <= valid_d;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            prst_q <= RST_PDN[PLL_RESET_BIT];
            off_q <= 1'b0;
        end else begin
            prst_q <= prst_d;
            off_q <= off_d;
        end
    end
    // -----------------------------------------------------------------
    // outputs straight from the flops
    // -----------------------------------------------------------------
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;
    assign CHAN_A_LANE_MAP = map_a_q;
    assign CHAN_B_LANE_MAP = map_b_q;
    assign LANE0_DEEMPHASIS = emp_q[0];
    assign LANE1_DEEMPHASIS = emp_q[1];
    assign LANE2_DEEMPHASIS = emp_q[2];
    assign LANE3_DEEMPHASIS = emp_q[3];
    assign SERIALIZER_PLL_FACTOR = factor_q;
    assign LANES_PER_CONV_FOUR = four_q;
    assign PLL_FACTOR_VALID = valid_q;
    assign SERIALIZER_PLL_RESET = prst_q;
    assign OUTER_LANES_OFF = off_q;
endmodule : sllcr_top
`default_nettype wire

// File: sllcr_props.sv
// checker: write-to-output properties of the lane config bank
`timescale 1ns/1ps
`default_nettype none
module sllcr_props
    import sllcr_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [sllcr_pkg::ADDR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    input wire logic [7:0] CHAN_A_LANE_MAP,
    input wire logic [5:0] LANE0_DEEMPHASIS,
    input wire logic [1:0] SERIALIZER_PLL_FACTOR,
    input wire logic LANES_PER_CONV_FOUR,
    input wire logic PLL_FACTOR_VALID,
    input wire logic OUTER_LANES_OFF
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    wire wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_SEL_I[0] & ~WB_ACK_O;
    wire [7:0] d = WB_DAT_I[7:0];
    wire w13 = wr && WB_ADR_I == {IDX_LANE0_DEEMPH, 2'b00};
    wire w16 = wr && WB_ADR_I == {IDX_SERIALIZER_PLL_MODE, 2'b00};
    wire w17 = wr && WB_ADR_I == {IDX_PLL_RESET_LANE_PDN, 2'b00};
    wire w31 = wr && WB_ADR_I == {IDX_CHAN_A_LANE_MAPPING, 2'b00};
    property p_four; w16 |-> ##2 LANES_PER_CONV_FOUR == ($past(d[1:0], 2) == 2'h0); endproperty
    a_four: assert property (p_four) else $error("lane count flag wrong");
    property p_valid; w16 |-> ##2 PLL_FACTOR_VALID == !$past(d[0], 2); endproperty
    a_valid: assert property (p_valid) else $error("factor valid flag wrong");
    property p_off; w17 |-> ##2 OUTER_LANES_OFF == ($past(d[5], 2) & $past(d[3], 2)); endproperty
    a_off: assert property (p_off) else $error("outer lane power wrong");
    property p_dem0; w13 |-> ##2 LANE0_DEEMPHASIS == $past(d[7:2], 2); endproperty
    a_dem0: assert property (p_dem0) else $error("lane0 de-emphasis wrong");
    property p_mapa; w31 |-> ##2 CHAN_A_LANE_MAP == $past(d, 2); endproperty
    a_mapa: assert property (p_mapa) else $error("lane map wrong");
    c_off: cover property (OUTER_LANES_OFF);
    c_two: cover property (PLL_FACTOR_VALID && !LANES_PER_CONV_FOUR);
    c_rd: cover property (WB_ACK_O && !WB_WE_I);
endmodule : sllcr_props
`default_nettype wire

// File: sllcr_rx_model.sv
// model: link receiver lane count
`timescale 1ns/1ps
`default_nettype none
module sllcr_rx_model (
    input wire logic four,
    output logic [2:0] lanes
);
    assign lanes = four ? 3'h4 : 3'h2;
endmodule : sllcr_rx_model
`default_nettype wire

// File: sllcr_bench.sv
// bench: wishbone tests of the lane config bank
`timescale 1ns/1ps
`default_nettype none
module serial_link_lane_config_regs_bench;
    import sllcr_pkg::*;
    logic clk = 0, rst = 1, req = 0, we = 0;
    logic [9:0] adr = 0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 0;
    logic [7:0] v;
    logic [7:0] w [8];
    wire [31:0] dout;
    wire ack, four, valid, prst, off;
    wire [7:0] ma, mb;
    wire [5:0] l0, l1, l2, l3;
    wire [1:0] fac;
    wire [2:0] lanes;
    int err_count = 0, total_checks = 0;
    logic [31:0] q [$];
    logic [7:0] idx [8] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h31, 8'h32};
    logic [7:0] msk [8] = '{8'hfc, 8'hfc, 8'hfc, 8'hfc, 8'h02, 8'h28, 8'hff, 8'hff};
    sllcr_top i_sllcr_top (.CLK_SYS(clk), .SYS_RST(rst), .WB_CYC_I(req), .WB_STB_I(req),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dout),
        .WB_ACK_O(ack), .CHAN_A_LANE_MAP(ma), .CHAN_B_LANE_MAP(mb), .LANE0_DEEMPHASIS(l0),
        .LANE1_DEEMPHASIS(l1), .LANE2_DEEMPHASIS(l2), .LANE3_DEEMPHASIS(l3),
        .SERIALIZER_PLL_FACTOR(fac), .LANES_PER_CONV_FOUR(four), .PLL_FACTOR_VALID(valid),
        .SERIALIZER_PLL_RESET(prst), .OUTER_LANES_OFF(off));
    sllcr_rx_model i_sllcr_rx_model (.four(four), .lanes(lanes));
    initial forever #25 clk = ~clk;
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic wb(input logic wr, input logic [7:0] i, input logic [7:0] d,
        input logic [3:0] s);
        @(posedge clk);
        req <= 1'b1;
        we <= wr;
        sel <= s;
        adr <= {i, 2'b00};
        dat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        req <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        q.push_back({24'h0, e});
        wb(1'b0, i, 8'h00, 4'h1);
    endtask : rd
    task automatic wo(input logic [7:0] i, input logic [7:0] d);
        wb(1'b1, i, d, 4'h1);
        @(posedge clk);
    endtask : wo
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    always @(posedge clk) if (ack === 1'b1 && we === 1'b0)
        cmp("rdata", q.pop_front(), dout);
    initial begin
        #300us;
        err_count++;
        conclude();
    end
    initial begin
        void'($urandom(32'ha285));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 8; k++) rd(idx[k], 8'h00);
        $display("test reset values done");
        for (int k = 0; k < 8; k++) begin
            w[k] = (8'($urandom()) & msk[k]) | (k == 0 ? 8'h02 : 8'h00);
            wo(idx[k], w[k]);
            rd(idx[k], w[k]);
        end
        cmp("map_a", w[6], ma);
        cmp("map_b", w[7], mb);
        cmp("lane1", w[0][7:2], l1);
        cmp("lane0", w[1][7:2], l0);
        cmp("lane2", w[2][7:2], l2);
        cmp("off", w[5][5] & w[5][3], off);
        $display("test random fields done");
        for (int n = 0; n < 7; n++) begin
            v = 8'(6'h3f >> (6 - n)) << 2;
            wo(8'h15, v);
            cmp("lane3", v[7:2], l3);
        end
        for (int c = 0; c < 4; c++) begin
            wo(8'h16, 8'(c));
            cmp("factor", c, fac);
            cmp("four", c == 0, four);
            cmp("valid", c % 2 == 0, valid);
            cmp("lanes", c == 0 ? 4 : 2, lanes);
            wo(8'h17, {2'b00, c[1], 1'b0, c[0], 3'b000});
            cmp("off", c == 3, off);
        end
        wo(8'h17, 8'h40);
        cmp("pll_rst", 1, prst);
        wo(8'h17, 8'h00);
        cmp("pll_rst", 0, prst);
        wb(1'b1, 8'h31, ~w[6], 4'he);
        @(posedge clk);
        rd(8'h31, w[6]);
        cmp("map_a", w[6], ma);
        wo(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        rd(8'h12, w[0]);
        $display("test codes and unmapped done");
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule : serial_link_lane_config_regs_bench
bind sllcr_top sllcr_props i_sllcr_props (.*);
`default_nettype wire
